// ### rsp_pkg.sv
// Purpose: Constants for the RAM section power control register bank
// Assumes: AXI4-Lite slave, 32-bit data, one aligned word per register
// Notes: Set and clear words act only on written ones
`default_nettype none
// Behaviour
// RQ1: Read-write control word at 0x920.
// RQ2: Low sixteen bits keep sections powered.
// RQ3: High sixteen bits keep contents when off.
// RQ4: Powered section always keeps its contents.
// RQ5: Unpowered section keeps contents only if retained.
// RQ6: Deep sleep switches every section off.
// RQ7: Set register at 0x924 sets written ones.
// RQ8: Set register reads back control word.
// RQ9: Reset gives all on, no retention.
// RQ10: Clear register at 0x928 clears written ones.
package rsp_pkg;
    localparam int          RSP_ADDR_W     = 12;
    localparam int          RSP_SECTIONS   = 16;
    localparam logic [11:0] RSP_OFF_CTRL   = 12'h920;
    localparam logic [11:0] RSP_OFF_SET    = 12'h924;
    localparam logic [11:0] RSP_OFF_CLR    = 12'h928;
    localparam logic [31:0] RSP_CTRL_RESET = 32'h0000ffff;
    localparam int          RSP_ON_LSB     = 0;
    localparam int          RSP_KEEP_LSB   = 16;
    localparam logic [1:0]  RSP_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RSP_RESP_SLVERR = 2'h2;
endpackage : rsp_pkg
`default_nettype wire

// ### rsp_ram_power.sv
// Purpose: AXI4-Lite register bank steering power and retention of sixteen RAM sections
// Assumes: Power switches and retention cells are driven from the outputs
// Assumes: deep_sleep comes from logic on aclk, so it is not synchronised
// Notes: Unmapped addresses answer SLVERR, reads return zero
//        Byte strobes apply to the control, set and clear words alike
`timescale 1ns/100ps
`default_nettype none
module rsp_ram_power (
    input  wire logic                             aclk,             // System clock
    input  wire logic                             aresetn,          // Sync reset, active low
    input  wire logic [rsp_pkg::RSP_ADDR_W-1:0]   s_axi_awaddr,     // Write address
    input  wire logic                             s_axi_awvalid,    // Write address valid
    output logic                                  s_axi_awready,    // Write address ready
    input  wire logic [31:0]                      s_axi_wdata,      // Write data
    input  wire logic [3:0]                       s_axi_wstrb,      // Byte enables
    input  wire logic                             s_axi_wvalid,     // Write data valid
    output logic                                  s_axi_wready,     // Write data ready
    output logic [1:0]                            s_axi_bresp,      // Write response
    output logic                                  s_axi_bvalid,     // Write response valid
    input  wire logic                             s_axi_bready,     // Write response ready
    input  wire logic [rsp_pkg::RSP_ADDR_W-1:0]   s_axi_araddr,     // Read address
    input  wire logic                             s_axi_arvalid,    // Read address valid
    output logic                                  s_axi_arready,    // Read address ready
    output logic [31:0]                           s_axi_rdata,      // Read data
    output logic [1:0]                            s_axi_rresp,      // Read response
    output logic                                  s_axi_rvalid,     // Read valid
    input  wire logic                             s_axi_rready,     // Read ready
    input  wire logic                             deep_sleep,       // Deep sleep state, same clock
    output logic [rsp_pkg::RSP_SECTIONS-1:0]      section_power_on, // Section powered
    output logic [rsp_pkg::RSP_SECTIONS-1:0]      section_retain    // Section contents kept
);
    import rsp_pkg::*;

    // Register word indices and per-section reset values
    localparam int                      WORD_W     = RSP_ADDR_W - 2;
    localparam logic [WORD_W-1:0]       WORD_CTRL  = RSP_OFF_CTRL[RSP_ADDR_W-1:2];
    localparam logic [WORD_W-1:0]       WORD_SET   = RSP_OFF_SET[RSP_ADDR_W-1:2];
    localparam logic [WORD_W-1:0]       WORD_CLR   = RSP_OFF_CLR[RSP_ADDR_W-1:2];
    localparam logic [RSP_SECTIONS-1:0] ON_RESET   = RSP_CTRL_RESET[RSP_ON_LSB +: RSP_SECTIONS];
    localparam logic [RSP_SECTIONS-1:0] KEEP_RESET = RSP_CTRL_RESET[RSP_KEEP_LSB +: RSP_SECTIONS];

    // Control word and held write request
    logic [31:0]             ctrl_r;
    logic [31:0]             ctrl_nxt;
    logic [RSP_ADDR_W-1:0]   awaddr_r;
    logic [31:0]             wdata_r;
    logic [3:0]              wstrb_r;
    logic                    aw_have_r;
    logic                    w_have_r;

    // Decode, handshake and response datapath
    logic [WORD_W-1:0]       aw_word;
    logic [WORD_W-1:0]       ar_word;
    logic                    wr_sel_ctrl;
    logic                    wr_sel_set;
    logic                    wr_sel_clr;
    logic                    wr_hit;
    logic                    rd_sel_ctrl;
    logic                    rd_sel_set;
    logic                    rd_sel_clr;
    logic                    rd_hit;
    logic                    aw_take;
    logic                    w_take;
    logic                    ar_take;
    logic                    do_write;
    logic [31:0]             strb_mask;
    logic [31:0]             wbits;
    logic [1:0]              bresp_nxt;
    logic [31:0]             rdata_nxt;
    logic [1:0]              rresp_nxt;

    // Per-section fields and next output values
    logic [RSP_SECTIONS-1:0] keep_on_bits;
    logic [RSP_SECTIONS-1:0] keep_contents_bits;
    logic [RSP_SECTIONS-1:0] power_nxt;
    logic [RSP_SECTIONS-1:0] retain_nxt;

    // A held half blocks its channel until the response drains
    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign ar_take       = s_axi_arvalid && s_axi_arready;
    assign do_write      = aw_have_r && w_have_r && !s_axi_bvalid;

    // Write address held until the write is done
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            awaddr_r  <= '0;
        end else if (aw_take) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have_r <= 1'b0;
        end
    end

    // Write data held until the write is done
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_r <= 1'b0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else if (w_take) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
        end else if (do_write) begin
            w_have_r <= 1'b0;
        end
    end

    // Word decode; the two low address bits are ignored
    assign aw_word     = awaddr_r[RSP_ADDR_W-1:2];
    assign ar_word     = s_axi_araddr[RSP_ADDR_W-1:2];
    assign wr_sel_ctrl = (aw_word == WORD_CTRL);
    assign wr_sel_set  = (aw_word == WORD_SET);
    assign wr_sel_clr  = (aw_word == WORD_CLR);
    assign wr_hit      = wr_sel_ctrl || wr_sel_set || wr_sel_clr;
    assign rd_sel_ctrl = (ar_word == WORD_CTRL);
    assign rd_sel_set  = (ar_word == WORD_SET);
    assign rd_sel_clr  = (ar_word == WORD_CLR);
    assign rd_hit      = rd_sel_ctrl || rd_sel_set || rd_sel_clr;

    // Byte lane enables widened to bit masks
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign strb_mask[lane*8 +: 8] = {8{wstrb_r[lane]}};
        end
    endgenerate
    assign wbits = wdata_r & strb_mask;

    // Next control word; set and clear touch only written ones
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (do_write) begin
            if (wr_sel_ctrl) begin
                ctrl_nxt = (ctrl_r & ~strb_mask) | wbits; // see RQ1
            end else if (wr_sel_set) begin
                ctrl_nxt = ctrl_r | wbits; // see RQ7
            end else if (wr_sel_clr) begin
                ctrl_nxt = ctrl_r & ~wbits; // see RQ10
            end
        end
    end

    // Control word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= RSP_CTRL_RESET; // see RQ9
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Misses answer SLVERR and change nothing
    assign bresp_nxt = wr_hit ? RSP_RESP_OKAY : RSP_RESP_SLVERR;

    // Write response held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RSP_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= bresp_nxt;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Set and clear words read back the control word itself
    always_comb begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = RSP_RESP_SLVERR;
        if (rd_hit) begin
            rdata_nxt = ctrl_r; // see RQ8 see RQ10
            rresp_nxt = RSP_RESP_OKAY;
        end
    end

    // Read response held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RSP_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdata_nxt;
            s_axi_rresp  <= rresp_nxt;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Keep-on and keep-contents fields
    assign keep_on_bits       = ctrl_r[RSP_ON_LSB +: RSP_SECTIONS];
    assign keep_contents_bits = ctrl_r[RSP_KEEP_LSB +: RSP_SECTIONS];

    // Deep sleep overrides keep-on, stored bits stay untouched
    genvar g;
    generate
        for (g = 0; g < RSP_SECTIONS; g++) begin : g_sec
            assign power_nxt[g]  = keep_on_bits[g] && !deep_sleep; // see RQ2 see RQ6
            assign retain_nxt[g] = power_nxt[g] || keep_contents_bits[g]; // see RQ3 see RQ4 see RQ5
        end
    endgenerate

    // Registered section drive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            section_power_on <= ON_RESET;
            section_retain   <= ON_RESET | KEEP_RESET;
        end else begin
            section_power_on <= power_nxt;
            section_retain   <= retain_nxt;
        end
    end
endmodule : rsp_ram_power
`default_nettype wire

// ### rsp_ram_power_assertions.sv
// Purpose: Port checks for rsp_ram_power
// Assumes: One clock, sync reset
// Notes: Bound to every instance
`timescale 1ns/100ps
`default_nettype none
module rsp_chk (
    input wire logic        aclk,             // Clock
    input wire logic        aresetn,          // Reset
    input wire logic        s_axi_awready,    // Bus
    input wire logic        s_axi_bvalid,     // Bus
    input wire logic        s_axi_bready,     // Bus
    input wire logic [11:0] s_axi_araddr,     // Bus
    input wire logic        s_axi_arvalid,    // Bus
    input wire logic        s_axi_arready,    // Bus
    input wire logic [31:0] s_axi_rdata,      // Bus
    input wire logic [1:0]  s_axi_rresp,      // Bus
    input wire logic        s_axi_rvalid,     // Bus
    input wire logic        s_axi_rready,     // Bus
    input wire logic        deep_sleep,       // Sleep
    input wire logic [15:0] section_power_on, // Power
    input wire logic [15:0] section_retain    // Retain
);
    import rsp_pkg::*;
    logic       ar;
    logic [9:0] ar_word;
    logic       ar_mapped;
    assign ar        = s_axi_arvalid && s_axi_arready;
    assign ar_word   = s_axi_araddr[11:2];
    assign ar_mapped = (ar_word == RSP_OFF_CTRL[11:2]) || (ar_word == RSP_OFF_SET[11:2])
                    || (ar_word == RSP_OFF_CLR[11:2]);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_SLEEP: assert property ($past(aresetn) && $past(deep_sleep) |-> section_power_on == '0)
        else $error("power on in sleep");
    AST_RET_ON: assert property ((section_power_on & ~section_retain) == '0)
        else $error("powered not retained");
    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved");
    AST_WBUSY: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("awready in response");
    AST_ARBUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready in response");
    AST_RLAT: assert property (ar |=> s_axi_rvalid)
        else $error("read answer late");
    AST_UNMAP: assert property (ar && !ar_mapped |=> s_axi_rresp == RSP_RESP_SLVERR && s_axi_rdata == '0)
        else $error("unmapped read");
    AST_MAPPED: assert property (ar && ar_mapped |=> s_axi_rresp == RSP_RESP_OKAY)
        else $error("mapped read refused");
    cover property (deep_sleep ##1 deep_sleep);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
endmodule : rsp_chk
bind rsp_ram_power rsp_chk u_chk (.*);
`default_nettype wire

// ### test_ram_section_power_ctrl.sv
// Purpose: Register and output tests for rsp_ram_power
// Assumes: AXI4-Lite master driven here
// Notes: Directed values only
`timescale 1ns/100ps
`default_nettype none
module test_ram_section_power_ctrl;
    import rsp_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, deep_sleep = 0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [15:0] section_power_on, section_retain;
    int num_errors = 0, tests_run = 0, cyc = 0;
    rsp_ram_power u_dut (
        .aclk             (aclk),
        .aresetn          (aresetn),
        .s_axi_awaddr     (s_axi_awaddr),
        .s_axi_awvalid    (s_axi_awvalid),
        .s_axi_awready    (s_axi_awready),
        .s_axi_wdata      (s_axi_wdata),
        .s_axi_wstrb      (s_axi_wstrb),
        .s_axi_wvalid     (s_axi_wvalid),
        .s_axi_wready     (s_axi_wready),
        .s_axi_bresp      (s_axi_bresp),
        .s_axi_bvalid     (s_axi_bvalid),
        .s_axi_bready     (s_axi_bready),
        .s_axi_araddr     (s_axi_araddr),
        .s_axi_arvalid    (s_axi_arvalid),
        .s_axi_arready    (s_axi_arready),
        .s_axi_rdata      (s_axi_rdata),
        .s_axi_rresp      (s_axi_rresp),
        .s_axi_rvalid     (s_axi_rvalid),
        .s_axi_rready     (s_axi_rready),
        .deep_sleep       (deep_sleep),
        .section_power_on (section_power_on),
        .section_retain   (section_retain)
    );
    initial forever #5 aclk = ~aclk;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("FAIL %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(s_axi_bresp), 32'(r));
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, e);
        chk("rresp", 32'(s_axi_rresp), 32'(r));
    endtask : rd
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            end_sim;
        end
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(RSP_OFF_CTRL, RSP_CTRL_RESET, RSP_RESP_OKAY);
        rd(RSP_OFF_SET, RSP_CTRL_RESET, RSP_RESP_OKAY);
        chk("on", 32'(section_power_on), 32'h0000ffff);
        chk("ret", 32'(section_retain), 32'h0000ffff);
        wr(RSP_OFF_CTRL, 32'h00ff00f0, 4'hf, RSP_RESP_OKAY);
        rd(RSP_OFF_CLR, 32'h00ff00f0, RSP_RESP_OKAY);
        chk("on", 32'(section_power_on), 32'h000000f0);
        chk("ret", 32'(section_retain), 32'h000000ff);
        wr(RSP_OFF_SET, 32'h01000100, 4'hf, RSP_RESP_OKAY);
        rd(RSP_OFF_CTRL, 32'h01ff01f0, RSP_RESP_OKAY);
        wr(RSP_OFF_CLR, 32'h00010010, 4'hf, RSP_RESP_OKAY);
        rd(RSP_OFF_CTRL, 32'h01fe01e0, RSP_RESP_OKAY);
        wr(RSP_OFF_CTRL, 32'hffffffff, 4'h1, RSP_RESP_OKAY);
        rd(RSP_OFF_CTRL, 32'h01fe01ff, RSP_RESP_OKAY);
        wr(12'h92c, 32'h0, 4'hf, RSP_RESP_SLVERR);
        rd(12'h92c, 32'h0, RSP_RESP_SLVERR);
        deep_sleep <= 1'b1;
        rd(RSP_OFF_CTRL, 32'h01fe01ff, RSP_RESP_OKAY);
        chk("on", 32'(section_power_on), 32'h0);
        chk("ret", 32'(section_retain), 32'h000001fe);
        deep_sleep <= 1'b0;
        rd(RSP_OFF_SET, 32'h01fe01ff, RSP_RESP_OKAY);
        chk("on", 32'(section_power_on), 32'h000001ff);
        chk("ret", 32'(section_retain), 32'h000001ff);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(RSP_OFF_CTRL, RSP_CTRL_RESET, RSP_RESP_OKAY);
        chk("on", 32'(section_power_on), 32'h0000ffff);
        chk("ret", 32'(section_retain), 32'h0000ffff);
        end_sim;
    end
endmodule : test_ram_section_power_ctrl
`default_nettype wire
